// [sampler_cfg_pkg.sv]
package sampler_cfg_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_SIZE = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SIZE_RESET = 32'h0000_0000;
   // control fields
   localparam int CTRL_TRIQ_LSB = 0;
   localparam int CTRL_UNNORM_BIT = 2;
   localparam int CTRL_MODE0_LSB = 3;
   localparam int CTRL_SURF_LSB = 12;
   localparam int CTRL_CUBE_CTRL_BIT = 15;
   localparam int MODE_W = 3;
   localparam int SIZE_FIELD_W = 4;
   localparam int NUM_COORD = 3;
   // trilinear quality codes
   localparam logic [1:0] tri_quality_full = 2'h0;
   localparam logic [1:0] tri_quality_medium = 2'h2;
   localparam logic [1:0] tri_quality_low = 2'h3;
   // drop thresholds in eighths of full weight: 25 and 37.5 percent
   localparam int MED_EIGHTHS = 2;
   localparam int LOW_EIGHTHS = 3;
   // surface kinds
   localparam logic [2:0] surface_kind_planar = 3'h1;
   localparam logic [2:0] surface_kind_volume = 3'h2;
   localparam logic [2:0] surface_kind_cubic = 3'h3;
   localparam logic [1:0] filter_pick_nearest = 2'h0;
   localparam logic [1:0] filter_pick_linear = 2'h1;
   // address modes
   localparam logic [2:0] addr_mode_repeat = 3'h0;
   localparam logic [2:0] addr_mode_reflect = 3'h1;
   localparam logic [2:0] addr_mode_edge_hold = 3'h2;
   localparam logic [2:0] addr_mode_cubic = 3'h3;
   localparam logic [2:0] addr_mode_edge_colour = 3'h4;
   localparam logic [2:0] addr_mode_reflect_single = 3'h5;
endpackage

// [sampler_addr_filter.sv]
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module sampler_addr_filter import sampler_cfg_pkg::*; #(
   parameter int COORD_W = 16,
   parameter int FRAC_W = 8,
   parameter int WEIGHT_W = 8
) (
   input wire logic clk_sys, // 200 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic [3:0] avs_address, // byte address
   input wire logic avs_read, // read strobe
   input wire logic avs_write, // write strobe
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic req_valid, // sample request
   input wire logic [WEIGHT_W-1:0] req_mip_weight, // weight of second mip
   input wire logic [COORD_W-1:0] req_coord_u, // first coordinate
   input wire logic [COORD_W-1:0] req_coord_v, // second coordinate
   input wire logic [COORD_W-1:0] req_coord_r, // third coordinate
   output logic res_valid, // result valid
   output logic res_use_mip0, // fetch first mip level
   output logic res_use_mip1, // fetch second mip level
   output logic [WEIGHT_W:0] res_mip_weight, // weight of second mip
   output logic [15:0] res_texel_u, // texel index
   output logic [15:0] res_texel_v, // texel index
   output logic [15:0] res_texel_r, // texel index
   output logic [NUM_COORD-1:0] res_border, // use border colour
   output logic [NUM_COORD-1:0] res_cube_cross // fetch from neighbour face
);
   // coordinate shifted by up to 15 map bits must stay inside a signed 32-bit word
   if (FRAC_W >= COORD_W || COORD_W > 16 || WEIGHT_W < 3 || WEIGHT_W > 16) begin : g_bad_param
      $error("sampler_addr_filter: unsupported parameters");
   end

   localparam logic [WEIGHT_W:0] FULL_W = (WEIGHT_W+1)'(1) << WEIGHT_W;
   localparam logic [WEIGHT_W:0] MED_TH = (WEIGHT_W+1)'(MED_EIGHTHS) << (WEIGHT_W - 3);
   localparam logic [WEIGHT_W:0] LOW_TH = (WEIGHT_W+1)'(LOW_EIGHTHS) << (WEIGHT_W - 3);

   logic [31:0] ctrl;
   logic [31:0] size;
   logic [15:0] sample_cnt;
   logic [15:0] reduced_cnt;
   logic [1:0] tri_q;
   logic unnorm_en;
   logic [2:0] surf_kind;
   logic bus_go;

   assign tri_q = ctrl[CTRL_TRIQ_LSB +: 2];
   assign unnorm_en = ctrl[CTRL_UNNORM_BIT];
   assign surf_kind = ctrl[CTRL_SURF_LSB +: 3];
   assign bus_go = (avs_read | avs_write) & ~avs_waitrequest;

   // one wait state: answer on the second cycle of every request
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
         size <= SIZE_RESET;
      end else if (avs_write && bus_go) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b] && avs_address == OFS_CTRL)
               ctrl[b*8 +: 8] <= avs_writedata[b*8 +: 8];
            if (avs_byteenable[b] && avs_address == OFS_SIZE)
               size[b*8 +: 8] <= avs_writedata[b*8 +: 8];
         end
      end
   end

   // unmapped offsets read as zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && avs_waitrequest) begin
         case (avs_address)
            OFS_CTRL: avs_readdata <= ctrl;
            OFS_SIZE: avs_readdata <= size;
            OFS_STATUS: avs_readdata <= {reduced_cnt, sample_cnt};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // trilinear level selection
   logic [WEIGHT_W:0] w1;
   logic [WEIGHT_W:0] w0;
   logic [WEIGHT_W:0] drop_th;
   logic next_mip0;
   logic next_mip1;
   logic [WEIGHT_W:0] next_weight;

   always_comb begin
      w1 = {1'b0, req_mip_weight};
      w0 = FULL_W - w1;
      next_mip0 = 1'b1;
      next_mip1 = 1'b1;
      next_weight = w1;
      case (tri_q)
         tri_quality_medium: drop_th = MED_TH;
         tri_quality_low: drop_th = LOW_TH;
         default: drop_th = '0;
      endcase
      if (w1 < drop_th) begin
         next_mip1 = 1'b0;
         next_weight = '0;
      end else if (w0 < drop_th) begin
         next_mip0 = 1'b0;
         next_weight = FULL_W;
      end
   end

   // maps an integer texel position into the map for one address mode
   function automatic logic [17:0] map_coord(input logic signed [31:0] t,
                                              input logic [3:0] lg,
                                              input logic [2:0] mode);
      logic signed [31:0] n;
      logic signed [31:0] m;
      logic signed [31:0] a;
      logic oob;
      n = 32'sd1 <<< lg;
      m = 32'sd0;
      oob = (t < 0) || (t >= n);
      case (mode)
         addr_mode_repeat: a = t & (n - 32'sd1);
         addr_mode_reflect: begin
            m = t & ((n <<< 1) - 32'sd1);
            a = (m >= n) ? ((n <<< 1) - 32'sd1 - m) : m;
         end
         addr_mode_reflect_single: begin
            a = (t < 0) ? (-t - 32'sd1) : t;
            a = (a >= n) ? (n - 32'sd1) : a;
         end
         // hold, cubic, colour and reserved codes clamp the index
         default: a = (t < 0) ? 32'sd0 : ((t >= n) ? (n - 32'sd1) : t);
      endcase
      map_coord = {(mode == addr_mode_edge_colour) && oob,
                   (mode == addr_mode_cubic) && oob,
                   a[15:0]};
   endfunction

   logic [COORD_W-1:0] coord_in [NUM_COORD];
   logic [15:0] texel [NUM_COORD];
   logic [2:0] eff_mode [NUM_COORD];
   assign coord_in[0] = req_coord_u;
   assign coord_in[1] = req_coord_v;
   assign coord_in[2] = req_coord_r;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_COORD; gi++) begin : g_coord
         logic [3:0] lg;
         logic signed [31:0] cx;
         logic signed [31:0] t;
         logic [17:0] mapped;
         assign lg = size[gi*SIZE_FIELD_W +: SIZE_FIELD_W];
         assign cx = 32'(signed'(coord_in[gi]));
         // normalized: scale by map size first, 0..1 covers the surface
         assign t = unnorm_en ? (cx >>> FRAC_W) : ((cx <<< lg) >>> FRAC_W);
         if (gi == 0) begin : g_first
            // cube surfaces take the cube control choice for the first coordinate only, not the field
            assign eff_mode[gi] = (surf_kind == surface_kind_cubic) ?
               (ctrl[CTRL_CUBE_CTRL_BIT] ? addr_mode_edge_hold : addr_mode_cubic) :
               ctrl[CTRL_MODE0_LSB +: MODE_W];
         end else begin : g_rest
            assign eff_mode[gi] = ctrl[CTRL_MODE0_LSB + gi*MODE_W +: MODE_W];
         end
         assign mapped = map_coord(t, lg, eff_mode[gi]);
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               texel[gi] <= 16'h0000;
               res_border[gi] <= 1'b0;
               res_cube_cross[gi] <= 1'b0;
            end else if (req_valid) begin
               texel[gi] <= mapped[15:0];
               res_border[gi] <= mapped[17];
               res_cube_cross[gi] <= mapped[16];
            end
         end
      end
   endgenerate

   assign res_texel_u = texel[0];
   assign res_texel_v = texel[1];
   assign res_texel_r = texel[2];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         res_valid <= 1'b0;
         res_use_mip0 <= 1'b0;
         res_use_mip1 <= 1'b0;
         res_mip_weight <= '0;
      end else begin
         res_valid <= req_valid;
         if (req_valid) begin
            res_use_mip0 <= next_mip0;
            res_use_mip1 <= next_mip1;
            res_mip_weight <= next_weight;
         end
      end
   end

   // counters wrap; software reads differences
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sample_cnt <= 16'h0000;
         reduced_cnt <= 16'h0000;
      end else if (req_valid) begin
         sample_cnt <= sample_cnt + 16'h0001;
         if (!(next_mip0 && next_mip1))
            reduced_cnt <= reduced_cnt + 16'h0001;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   full_both_a: assert property (req_valid && tri_q == tri_quality_full
      |=> res_use_mip0 && res_use_mip1) else $error("full quality dropped a level");
   med_drop_a: assert property (req_valid && tri_q == tri_quality_medium && w1 < MED_TH
      |=> res_use_mip0 && !res_use_mip1) else $error("medium quality kept light level");
   med_keep_a: assert property (req_valid && tri_q == tri_quality_medium
      && w1 >= MED_TH && w0 >= MED_TH
      |=> res_use_mip0 && res_use_mip1) else $error("medium quality dropped heavy level");
   low_drop_a: assert property (req_valid && tri_q == tri_quality_low && w0 < LOW_TH
      |=> !res_use_mip0 && res_use_mip1 && res_mip_weight == FULL_W)
      else $error("low quality kept light level");
   unnorm_step_a: assert property (req_valid && unnorm_en
      && eff_mode[0] == addr_mode_repeat && size[3:0] == 4'h4
      |=> res_texel_u[3:0] == $past(req_coord_u[FRAC_W +: 4]))
      else $error("unnormalized step is not one texel");
   norm_span_a: assert property (req_valid && !unnorm_en && size[3:0] == 4'h4
      && eff_mode[0] == addr_mode_edge_hold && req_coord_u == COORD_W'(1 << FRAC_W)
      |=> res_texel_u == 16'h000f) else $error("normalized one does not reach edge");
   cube_cross_a: assert property (req_valid && eff_mode[0] == addr_mode_cubic
      && req_coord_u[COORD_W-1] |=> res_cube_cross[0] && res_texel_u == 16'h0000)
      else $error("cube edge not flagged");
   border_a: assert property (req_valid && eff_mode[1] == addr_mode_edge_colour
      && req_coord_v[COORD_W-1] |=> res_border[1]) else $error("border missed");
   reflect_once_a: assert property (req_valid && eff_mode[0] == addr_mode_reflect_single
      && unnorm_en && req_coord_u == {COORD_W{1'b1}}
      |=> res_texel_u == 16'h0000 && !res_border[0]) else $error("mirror once wrong");
   cube_override_a: assert property (surf_kind == surface_kind_cubic
      |-> eff_mode[0] == addr_mode_cubic || eff_mode[0] == addr_mode_edge_hold)
      else $error("cube override ignored");
   repeat_wrap_a: assert property (req_valid && eff_mode[2] == addr_mode_repeat
      |=> !res_border[2] && !res_cube_cross[2]) else $error("repeat flagged edge");
   bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");

   reduced_c: cover property (req_valid && !(next_mip0 && next_mip1));
   border_c: cover property (res_valid && res_border[0]);
   cross_c: cover property (res_valid && res_cube_cross[0]);
   write_c: cover property (avs_write && !avs_waitrequest && avs_address == OFS_CTRL);
endmodule

// [sample_source.sv]
`timescale 1ns/1ps
module sample_source (
   input wire logic clk_sys, // clock
   output logic req_valid, // sample request
   output logic [7:0] req_mip_weight, // second mip weight
   output logic [15:0] req_coord_u, // first coordinate
   output logic [15:0] req_coord_v, // second coordinate
   output logic [15:0] req_coord_r // third coordinate
);
   initial begin
      req_valid = 1'b0;
      req_mip_weight = 8'h00;
      req_coord_u = 16'h0000;
      req_coord_v = 16'h0000;
      req_coord_r = 16'h0000;
   end
   // idle lines flip so a stale value is never taken for a live one
   task automatic send(input logic [7:0] w, input logic [15:0] u, v, r);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_mip_weight <= w;
      req_coord_u <= u;
      req_coord_v <= v;
      req_coord_r <= r;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_mip_weight <= ~w;
      req_coord_u <= ~u;
      req_coord_v <= ~v;
      req_coord_r <= ~r;
   endtask
endmodule

// [tb_texture_sampler_address_filter_cfg.sv]
`timescale 1ns/1ps
module tb_texture_sampler_address_filter_cfg;
   import sampler_cfg_pkg::*;
   logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, req_valid, res_valid;
   logic res_use_mip0, res_use_mip1;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [7:0] req_mip_weight;
   logic [15:0] req_coord_u, req_coord_v, req_coord_r, res_texel_u, res_texel_v, res_texel_r;
   logic [8:0] res_mip_weight;
   logic [2:0] res_border, res_cube_cross;
   int n_errors = 0;
   int check_count = 0;
   int tu[6] = '{4, 11, 15, 0, 0, 15};
   int tv[6] = '{13, 2, 0, 0, 0, 2};
   logic [1:0] tq[8] = '{0, 2, 2, 2, 3, 3, 3, 0};
   logic [7:0] tw[8] = '{1, 63, 64, 193, 95, 161, 96, 255};
   logic [10:0] te[8] = '{11'h601, 11'h400, 11'h640, 11'h300, 11'h400, 11'h300, 11'h660, 11'h6ff};

   sampler_addr_filter uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .req_valid(req_valid), .req_mip_weight(req_mip_weight), .req_coord_u(req_coord_u),
      .req_coord_v(req_coord_v), .req_coord_r(req_coord_r), .res_valid(res_valid),
      .res_use_mip0(res_use_mip0), .res_use_mip1(res_use_mip1),
      .res_mip_weight(res_mip_weight), .res_texel_u(res_texel_u), .res_texel_v(res_texel_v),
      .res_texel_r(res_texel_r), .res_border(res_border), .res_cube_cross(res_cube_cross));
   sample_source src (.clk_sys(clk_sys), .req_valid(req_valid),
      .req_mip_weight(req_mip_weight), .req_coord_u(req_coord_u),
      .req_coord_v(req_coord_v), .req_coord_r(req_coord_r));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask

   // read right after a rising edge, waitrequest still shows what that edge sampled
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         n_errors++;
         test_done();
      end
   endtask

   task automatic smp(input logic [7:0] w, input logic [15:0] u, v, r);
      src.send(w, u, v, r);
      #1;
      chk("res_valid", 32'h1, res_valid);
   endtask

   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      bus(0, OFS_CTRL, 0);
      chk("ctrl", CTRL_RESET, q);
      bus(0, OFS_SIZE, 0);
      chk("size", SIZE_RESET, q);
      bus(1, OFS_STATUS, 32'h1234_5678);
      bus(0, 4'hc, 0);
      chk("unmapped", 32'h0, q);
      $display("test registers done");
      bus(1, OFS_SIZE, 32'h0000_0444);
      for (int i = 0; i < 8; i++) begin
         bus(1, OFS_CTRL, {30'h0, tq[i]});
         smp(tw[i], 16'h0050, 16'h0050, 16'h0050);
         chk("mip", {21'h0, te[i]}, {res_use_mip0, res_use_mip1, res_mip_weight});
      end
      bus(0, OFS_STATUS, 0);
      chk("status", 32'h0004_0008, q);
      $display("test trilinear done");
      for (int m = 0; m < 6; m++) begin
         bus(1, OFS_CTRL, (m << 3) | (m << 6) | (m << 9));
         smp(8'h00, 16'h0140, 16'hffd0, 16'h0050);
         chk("border", (m == 4) ? 3 : 0, res_border);
         chk("cross", (m == 3) ? 3 : 0, res_cube_cross);
         if (m != 3 && m != 4) begin
            chk("texel_u", tu[m], res_texel_u);
            chk("texel_v", tv[m], res_texel_v);
            chk("texel_r", 5, res_texel_r);
         end
      end
      bus(1, OFS_CTRL, 2 << 3);
      smp(8'h00, 16'h0100, 16'h0080, 16'h0000);
      chk("norm_edge", 15, res_texel_u);
      chk("norm_half", 8, res_texel_v);
      $display("test address modes done");
      // planar surface, all lod fields left at zero, as unnormalized use demands
      bus(1, OFS_CTRL, 32'h1000 | 4);
      smp(8'h00, 16'h0500, 16'h0500, 16'h0500);
      chk("unnorm_u", 5, res_texel_u);
      bus(1, OFS_CTRL, 32'h1000 | (5 << 3) | 4);
      smp(8'h00, 16'hffff, 16'h0500, 16'h0500);
      chk("unnorm_once_u", 0, res_texel_u);
      $display("test unnormalized done");
      bus(1, OFS_CTRL, 32'h3000);
      smp(8'h00, 16'hffd0, 16'h0140, 16'h0140);
      chk("cube_cross", 3'h1, res_cube_cross);
      bus(1, OFS_CTRL, 32'hb000);
      smp(8'h00, 16'h0140, 16'h0140, 16'h0140);
      chk("cube_hold_x", 3'h0, res_cube_cross);
      chk("cube_hold_u", 15, res_texel_u);
      chk("cube_v", 4, res_texel_v);
      $display("test cube override done");
      test_done();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      test_done();
   end
endmodule
